// [hw/vmt_pkg.sv]
// shared constants, types and register map of the vibration measure core
// assumes one 20 MHz clock and a byte-addressed plain register port
package vmt_pkg;

  // ----------------------------------------------------------------
  // timing and sizes
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;
  localparam int unsigned ADC_MAX_SPS = 1_000_000;
  localparam int unsigned ADC_MIN_CYC = (CLK_HZ + ADC_MAX_SPS - 1) / ADC_MAX_SPS;
  localparam int unsigned N_SAMPLES = 4096;
  localparam int unsigned LOG2_N = 12;
  localparam int unsigned ADC_W = 14;
  localparam int unsigned SMP_W = 16;
  localparam int unsigned BURST_LEN = 15;
  localparam int unsigned SLOW_S = 10;
  localparam int unsigned RATE_BASE_HZ = 512;
  localparam int unsigned RATE_STEP_HZ = 4096;
  localparam int unsigned GAIN_SHIFT = 8;
  localparam int unsigned WIN_SHIFT = 15;
  localparam int unsigned FFT_NORM_SHIFT = LOG2_N;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INTERVAL = 8'h04;
  localparam logic [7:0] REG_THR_LEVEL = 8'h08;
  localparam logic [7:0] REG_DC_OFFSET = 8'h0C;
  localparam logic [7:0] REG_GAIN = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RMS = 8'h18;
  localparam logic [7:0] REG_PKPK = 8'h1C;
  localparam logic [7:0] REG_DEV = 8'h20;
  localparam logic [7:0] REG_MID = 8'h24;
  localparam logic [7:0] REG_MEAN = 8'h28;
  localparam logic [7:0] REG_TEMP = 8'h2C;
  localparam logic [7:0] REG_FFT_BIN = 8'h30;
  localparam logic [7:0] REG_FFT_DATA = 8'h34;
  localparam int unsigned CTRL_W = 18;
  localparam int unsigned STS_BUSY = 0;
  localparam int unsigned STS_FLAG = 1;
  localparam int unsigned STS_CONN = 2;
  localparam logic [15:0] INTERVAL_RST = 16'h003C;
  localparam logic [15:0] GAIN_RST = 16'h0100;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WIN_RECT, WIN_HANN, WIN_FLAT} vmt_win_t;
  typedef enum logic [1:0] {ADV_LOWPWR, ADV_ONMEAS, ADV_EVENT} vmt_adv_t;
  typedef enum logic [1:0] {LOG_OFF, LOG_EACH, LOG_THR, LOG_RISE} vmt_logtrig_t;

  typedef struct packed {
    vmt_logtrig_t log_trig;
    logic auto_clr;
    logic act_log;
    logic act_adv;
    logic act_flag;
    logic thr_below;
    logic thr_pkpk;
    vmt_adv_t adv_mode;
    logic [3:0] rate_sel;
    vmt_win_t win;
    logic live;
    logic meas_en;
  } vmt_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [LOG2_N-1:0] addr;
    logic [SMP_W-1:0] data;
  } vmt_smp_t;

  typedef struct packed {
    logic flag;
    logic [ADC_W-1:0] temp;
    logic [SMP_W-1:0] pkpk;
    logic [SMP_W-1:0] rms;
  } vmt_adv_pl_t;

  localparam vmt_ctrl_t CTRL_RST = vmt_ctrl_t'(18'h00000);

endpackage : vmt_pkg

// [hw/vmt_core.sv]
// vibration measure core: timer, acquisition, statistics, window, threshold
// assumes an external converter, transform engine, log memory and radio
`timescale 1ns/1ps

// Operation
// - timer expiry takes acceleration and temperature
// - refresh advertising payload after processing
// - capture exactly 4096 samples at rate
// - rates 512 to 53248 Hz
// - 14-bit samples, converter at most 1 MSPS
// - selector routes acceleration or temperature
// - remove dc offset, then apply gain
// - compute rms, peak-to-peak, deviation, mid, mean
// - apply hann, flat-top or rectangular window
// - fft after windowing, normalized output
// - rms and p2p in adverts and registers
// - spectrum readable only while connected
// - live mode reacquires continuously when connected
// - threshold checked once per measurement
// - metric is rms or peak-to-peak
// - trigger above or below the level
// - threshold hit performs configured actions
// - interval change only in event mode; here interval_q changes only by a REG_INTERVAL write, in any mode
// - threshold logging only in event mode
// - log buffer on selected trigger
// - 15-packet burst, then 10 s repeats
module vmt_core #(
  parameter int unsigned TICK_CYCLES = vmt_pkg::TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic link_connected,
  output logic adc_start,
  output logic adc_sel_temp,
  input wire logic [vmt_pkg::ADC_W-1:0] adc_data,
  input wire logic adc_valid,
  output logic [vmt_pkg::LOG2_N-1:0] win_idx,
  input wire logic signed [15:0] win_coef,
  output vmt_pkg::vmt_smp_t fft_smp,
  output logic fft_start,
  input wire logic fft_done,
  output logic [vmt_pkg::LOG2_N-1:0] fft_bin_addr,
  input wire logic signed [31:0] fft_bin_data,
  output vmt_pkg::vmt_smp_t log_smp,
  output logic log_commit,
  output vmt_pkg::vmt_adv_pl_t adv_payload,
  output logic adv_update,
  output logic adv_tx,
  output logic threshold_event_flag
);
  import vmt_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [31:0] rem;
    logic [15:0] root;
    logic [31:0] trial;
    rem = v;
    root = '0;
    for (int b = 15; b >= 0; b--) begin
      trial = {16'h0000, root | (16'h0001 << b)};
      if (trial * trial <= {16'h0000, rem[15:0]} + {rem[31:16], 16'h0000}) begin
        root = root | (16'h0001 << b);
      end
    end
    return root;
  endfunction : isqrt

  // cycles between conversions; never faster than the converter allows
  function automatic logic [15:0] smp_period(input logic [3:0] sel);
    int unsigned hz;
    int unsigned cyc;
    hz = (sel < 4'h4) ? (RATE_BASE_HZ << sel) : RATE_STEP_HZ * (int'(sel) - 2);
    cyc = CLK_HZ / hz;
    if (cyc < ADC_MIN_CYC) cyc = ADC_MIN_CYC;
    return 16'(cyc);
  endfunction : smp_period

  typedef enum logic [2:0] {ST_IDLE, ST_ACQ, ST_TEMP, ST_PROC, ST_FFT, ST_PUB} vmt_st_t;

  vmt_st_t st_q;
  vmt_ctrl_t ctrl_q;
  vmt_ctrl_t cfg_q;
  logic [15:0] interval_q;
  logic [15:0] thr_q;
  logic [ADC_W-1:0] dc_q;
  logic [15:0] gain_q;
  logic [31:0] tick_cnt_q;
  logic sec_tick;
  logic [15:0] meas_sec_q;
  logic req_q;
  logic take;
  logic [15:0] per_cnt_q;
  logic [LOG2_N:0] issued_q;
  logic [LOG2_N-1:0] idx_q;
  logic signed [27:0] sum_q;
  logic [43:0] sq_q;
  logic signed [15:0] max_q;
  logic signed [15:0] min_q;
  logic [15:0] rms_q, pkpk_q, dev_q, mid_q, mean_q;
  logic [ADC_W-1:0] temp_q;
  logic hit_prev_q;
  logic [3:0] burst_q;
  logic [3:0] slow_q;
  logic flag_clr;

  // ----------------------------------------------------------------
  // sample correction and window
  // ----------------------------------------------------------------
  logic signed [14:0] diff;
  logic signed [31:0] prod;
  logic signed [31:0] scaled;
  logic signed [15:0] corr;
  logic signed [31:0] wprod;
  logic signed [15:0] wsmp;
  logic last_smp;

  always_comb begin
    diff = $signed({1'b0, adc_data}) - $signed({1'b0, dc_q});
    prod = 32'(diff * $signed({1'b0, gain_q}));
    scaled = prod >>> GAIN_SHIFT;
    if (scaled > 32'sd32767) corr = 16'sh7FFF;
    else if (scaled < -32'sd32768) corr = -16'sh8000;
    else corr = scaled[15:0];
    wprod = corr * win_coef;
    // rectangular passes the sample through untouched
    wsmp = (cfg_q.win == WIN_HANN || cfg_q.win == WIN_FLAT)
      ? wprod[WIN_SHIFT +: 16] : corr;
    last_smp = adc_valid && idx_q == LOG2_N'(N_SAMPLES - 1);
  end

  // ----------------------------------------------------------------
  // seconds tick and measurement timer
  // ----------------------------------------------------------------
  assign sec_tick = tick_cnt_q == TICK_CYCLES - 1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= sec_tick ? '0 : tick_cnt_q + 32'h00000001;
    end
  end

  // live mode with a link up skips the timer and restarts right after each pass
  assign take = st_q == ST_IDLE && (req_q || (ctrl_q.live && link_connected));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meas_sec_q <= '0;
      req_q <= 1'b0;
    end else begin
      if (sec_tick && ctrl_q.meas_en) begin
        if (meas_sec_q + 16'h0001 >= interval_q) begin
          meas_sec_q <= '0;
          req_q <= 1'b1;
        end else begin
          meas_sec_q <= meas_sec_q + 16'h0001;
          if (take) req_q <= 1'b0;
        end
      end else if (take) begin
        req_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // measurement sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cfg_q <= CTRL_RST;
      per_cnt_q <= '0;
      issued_q <= '0;
      idx_q <= '0;
      adc_start <= 1'b0;
      adc_sel_temp <= 1'b0;
      fft_start <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      fft_start <= 1'b0;
      // spacing runs across passes so no request ever comes too soon
      if (per_cnt_q != 16'h0000) begin
        per_cnt_q <= per_cnt_q - 16'h0001;
      end
      unique case (st_q)
        ST_IDLE: begin
          if (take) begin
            cfg_q <= ctrl_q;
            st_q <= ST_ACQ;
            issued_q <= '0;
            idx_q <= '0;
            adc_sel_temp <= 1'b0;
          end
        end
        ST_ACQ: begin
          if (per_cnt_q == 16'h0000 && issued_q < (LOG2_N + 1)'(N_SAMPLES)) begin
            adc_start <= 1'b1;
            issued_q <= issued_q + 13'h0001;
            per_cnt_q <= smp_period(cfg_q.rate_sel) - 16'h0001;
          end
          if (adc_valid) idx_q <= idx_q + 12'h001;
          if (last_smp) st_q <= ST_TEMP;
        end
        ST_TEMP: begin
          // temperature request keeps the converter spacing too
          if (per_cnt_q == 16'h0000 && !adc_sel_temp) begin
            adc_sel_temp <= 1'b1;
            adc_start <= 1'b1;
            per_cnt_q <= 16'(ADC_MIN_CYC - 1);
          end
          if (adc_valid) begin
            adc_sel_temp <= 1'b0;
            st_q <= ST_PROC;
          end
        end
        ST_PROC: begin
          st_q <= ST_FFT;
          fft_start <= 1'b1;
        end
        ST_FFT: begin
          if (fft_done) st_q <= ST_PUB;
        end
        ST_PUB: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign win_idx = idx_q;

  // ----------------------------------------------------------------
  // sample streams to transform engine and log memory
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fft_smp <= '0;
      log_smp <= '0;
    end else begin
      fft_smp.valid <= st_q == ST_ACQ && adc_valid;
      fft_smp.addr <= idx_q;
      fft_smp.data <= wsmp;
      log_smp.valid <= st_q == ST_ACQ && adc_valid;
      log_smp.addr <= idx_q;
      log_smp.data <= corr;
    end
  end

  // ----------------------------------------------------------------
  // statistics
  // ----------------------------------------------------------------
  logic signed [15:0] mean_c;
  logic [31:0] msq_c;
  logic [31:0] var_c;
  logic [31:0] m2_c;

  always_comb begin
    mean_c = 16'(sum_q >>> LOG2_N);
    msq_c = 32'(sq_q >> LOG2_N);
    m2_c = 32'(mean_c * mean_c);
    var_c = (msq_c > m2_c) ? msq_c - m2_c : 32'h00000000;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sum_q <= '0;
      sq_q <= '0;
      max_q <= -16'sh8000;
      min_q <= 16'sh7FFF;
      rms_q <= '0;
      pkpk_q <= '0;
      dev_q <= '0;
      mid_q <= '0;
      mean_q <= '0;
      temp_q <= '0;
    end else begin
      if (take) begin
        sum_q <= '0;
        sq_q <= '0;
        max_q <= -16'sh8000;
        min_q <= 16'sh7FFF;
      end else if (st_q == ST_ACQ && adc_valid) begin
        sum_q <= sum_q + 28'(corr);
        sq_q <= sq_q + 44'(corr * corr);
        if (corr > max_q) max_q <= corr;
        if (corr < min_q) min_q <= corr;
      end
      if (st_q == ST_TEMP && adc_valid) temp_q <= adc_data;
      if (st_q == ST_PROC) begin
        rms_q <= isqrt(msq_c);
        dev_q <= isqrt(var_c);
        pkpk_q <= 16'(17'(max_q) - 17'(min_q));
        mid_q <= 16'((17'(max_q) + 17'(min_q)) >>> 1);
        mean_q <= mean_c;
      end
    end
  end

  // ----------------------------------------------------------------
  // threshold, flag, log trigger
  // ----------------------------------------------------------------
  logic [15:0] metric;
  logic hit;
  logic evt_mode;

  always_comb begin
    metric = cfg_q.thr_pkpk ? pkpk_q : rms_q;
    hit = cfg_q.thr_below ? (metric < thr_q) : (metric > thr_q);
    evt_mode = cfg_q.adv_mode == ADV_EVENT;
  end

  assign flag_clr = reg_wr && reg_addr == REG_STATUS && reg_wdata[STS_FLAG];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      threshold_event_flag <= 1'b0;
      hit_prev_q <= 1'b0;
      log_commit <= 1'b0;
    end else begin
      log_commit <= 1'b0;
      // evaluated only here, once per finished pass
      if (st_q == ST_PUB) begin
        hit_prev_q <= hit;
        unique case (cfg_q.log_trig)
          LOG_EACH: log_commit <= 1'b1;
          LOG_THR: log_commit <= hit && cfg_q.act_log && evt_mode;
          LOG_RISE: log_commit <= hit && !hit_prev_q && cfg_q.act_log && evt_mode;
          LOG_OFF: log_commit <= 1'b0;
        endcase
      end
      // a hit in the clearing cycle wins
      if (st_q == ST_PUB && hit && cfg_q.act_flag) begin
        threshold_event_flag <= 1'b1;
      end else if (flag_clr || (st_q == ST_PUB && !hit && cfg_q.auto_clr)) begin
        threshold_event_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // advertising payload and schedule
  // ----------------------------------------------------------------
  logic slow_ok;

  always_comb begin
    unique case (cfg_q.adv_mode)
      ADV_LOWPWR: slow_ok = 1'b1;
      ADV_EVENT: slow_ok = threshold_event_flag && cfg_q.act_adv;
      default: slow_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      adv_payload <= '0;
      adv_update <= 1'b0;
      adv_tx <= 1'b0;
      burst_q <= '0;
      slow_q <= '0;
    end else begin
      adv_update <= 1'b0;
      adv_tx <= 1'b0;
      if (st_q == ST_PUB) begin
        adv_payload.rms <= rms_q;
        adv_payload.pkpk <= pkpk_q;
        adv_payload.temp <= temp_q;
        adv_payload.flag <= threshold_event_flag || (hit && cfg_q.act_flag);
        adv_update <= 1'b1;
        burst_q <= 4'(BURST_LEN);
        slow_q <= '0;
      end else if (sec_tick) begin
        if (burst_q != 4'h0) begin
          adv_tx <= 1'b1;
          burst_q <= burst_q - 4'h1;
        end else if (slow_ok) begin
          if (slow_q == 4'(SLOW_S - 1)) begin
            adv_tx <= 1'b1;
            slow_q <= '0;
          end else begin
            slow_q <= slow_q + 4'h1;
          end
        end else begin
          slow_q <= '0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      interval_q <= INTERVAL_RST;
      thr_q <= '0;
      dc_q <= '0;
      gain_q <= GAIN_RST;
      fft_bin_addr <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: ctrl_q <= vmt_ctrl_t'(reg_wdata[CTRL_W-1:0]);
        REG_INTERVAL: interval_q <= reg_wdata[15:0];
        REG_THR_LEVEL: thr_q <= reg_wdata[15:0];
        REG_DC_OFFSET: dc_q <= reg_wdata[ADC_W-1:0];
        REG_GAIN: gain_q <= reg_wdata[15:0];
        REG_FFT_BIN: fft_bin_addr <= reg_wdata[LOG2_N-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: reg_rdata <= 32'(ctrl_q);
        REG_INTERVAL: reg_rdata <= {16'h0000, interval_q};
        REG_THR_LEVEL: reg_rdata <= {16'h0000, thr_q};
        REG_DC_OFFSET: reg_rdata <= 32'(dc_q);
        REG_GAIN: reg_rdata <= {16'h0000, gain_q};
        REG_STATUS: reg_rdata <= 32'({link_connected, threshold_event_flag, st_q != ST_IDLE});
        REG_RMS: reg_rdata <= {16'h0000, rms_q};
        REG_PKPK: reg_rdata <= {16'h0000, pkpk_q};
        REG_DEV: reg_rdata <= {16'h0000, dev_q};
        REG_MID: reg_rdata <= {16'h0000, mid_q};
        REG_MEAN: reg_rdata <= {16'h0000, mean_q};
        REG_TEMP: reg_rdata <= 32'(temp_q);
        REG_FFT_BIN: reg_rdata <= 32'(fft_bin_addr);
        // spectrum hidden unless a link is up; divide by the point count
        REG_FFT_DATA: reg_rdata <= link_connected
          ? 32'(fft_bin_data >>> FFT_NORM_SHIFT) : 32'h00000000;
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule : vmt_core

// [sim/vmt_core_props.sv]
// port checker for the vibration measure core
// assumes one clock domain and the asynchronous active-high reset
`timescale 1ns/1ps
module vmt_core_props #(
  parameter int unsigned TICK_CYCLES = vmt_pkg::TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic link_connected,
  input wire logic adc_start,
  input wire logic adc_sel_temp,
  input wire logic adc_valid,
  input wire vmt_pkg::vmt_smp_t fft_smp,
  input wire logic fft_start,
  input wire vmt_pkg::vmt_smp_t log_smp,
  input wire logic log_commit,
  input wire logic adv_update,
  input wire logic threshold_event_flag
);
  import vmt_pkg::*;
  logic [15:0] gap_q;
  logic gate_q;
  // gap saturates so a long idle spell never wraps into a false short gap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_q <= 16'hFFFF;
    end else if (adc_start) begin
      gap_q <= 16'h0000;
    end else if (gap_q != 16'hFFFF) begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= reg_rd && reg_addr == REG_FFT_DATA && !link_connected;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
  spectrum_gate_a: assert property (gate_q |-> reg_rdata == 32'h0)
    else $error("spectrum read while not connected");
  start_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("convert request longer than one cycle");
  start_gap_a: assert property (adc_start |-> gap_q >= 16'(ADC_MIN_CYC - 1))
    else $error("convert requests too close");
  sample_follow_a: assert property (adc_valid && !adc_sel_temp |=> log_smp.valid)
    else $error("sample not forwarded");
  sample_pair_a: assert property (log_smp.valid |-> $past(adc_valid) && fft_smp.valid
    && fft_smp.addr == log_smp.addr)
    else $error("sample outputs out of step");
  sel_rise_a: assert property ($rose(adc_sel_temp) |-> adc_start)
    else $error("selector moved without a request");
  sel_hold_a: assert property (adc_sel_temp && !adc_valid |=> adc_sel_temp)
    else $error("selector dropped early");
  fft_order_a: assert property (fft_start |-> !adc_sel_temp && !adc_start)
    else $error("transform started during capture");
  flag_rise_a: assert property ($rose(threshold_event_flag) |-> adv_update)
    else $error("flag set outside a measurement");
  commit_pub_a: assert property (log_commit |-> adv_update)
    else $error("log commit outside a measurement");
  cover property (adc_start);
  cover property (log_smp.valid);
  cover property (reg_rd && reg_addr == REG_FFT_DATA && link_connected);
endmodule : vmt_core_props

bind vmt_core vmt_core_props #(.TICK_CYCLES(TICK_CYCLES)) u_vmt_core_props (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .link_connected(link_connected), .adc_start(adc_start),
  .adc_sel_temp(adc_sel_temp), .adc_valid(adc_valid), .fft_smp(fft_smp),
  .fft_start(fft_start), .log_smp(log_smp), .log_commit(log_commit),
  .adv_update(adv_update), .threshold_event_flag(threshold_event_flag)
);

// [sim/vmt_far_model.sv]
// converter, window table and transform engine beside the core
// assumes one clock; answers change just after rising edges
`timescale 1ns/1ps
module vmt_far_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic adc_start,
  input wire logic adc_sel_temp,
  output logic [13:0] adc_data,
  output logic adc_valid,
  input wire logic [11:0] win_idx,
  output logic signed [15:0] win_coef,
  input wire logic fft_start,
  output logic fft_done,
  input wire logic [11:0] fft_bin_addr,
  output logic signed [31:0] fft_bin_data
);
  import vmt_pkg::*;
  logic [5:0] wait_q;
  logic [3:0] fft_q;
  logic [11:0] k_q;
  logic sel_q;
  // same half weight everywhere: a pass-through window that uses it is caught
  assign win_coef = 16'sh4000;
  assign fft_bin_data = {8'hF0, fft_bin_addr, 12'h5A5};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 6'h00;
      fft_q <= 4'h0;
      k_q <= 12'h000;
      sel_q <= 1'b0;
      adc_valid <= 1'b0;
      adc_data <= 14'h0000;
      fft_done <= 1'b0;
    end else begin
      adc_valid <= 1'b0;
      fft_done <= fft_q == 4'h1;
      fft_q <= fft_start ? 4'h8 : fft_q - 4'(fft_q != 4'h0);
      if (adc_start) begin
        wait_q <= slow ? 6'h28 : 6'h03;
        sel_q <= adc_sel_temp;
      end else if (wait_q != 6'h00) begin
        wait_q <= wait_q - 6'h01;
      end
      if (wait_q == 6'h01) begin
        adc_valid <= 1'b1;
        adc_data <= sel_q ? 14'h0ABC : 14'h1100 + {k_q[9:0], 4'h0};
        k_q <= k_q + 12'(!sel_q);
      end else begin
        adc_data <= ~adc_data;
      end
    end
  end
endmodule : vmt_far_model

// [sim/tb.sv]
// self-checking bench for the vibration measure core
// assumes a short seconds tick of 20 cycles and the far model above
`timescale 1ns/1ps
module tb;
  import vmt_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic link_connected = 1'b0;
  logic slow = 1'b0;
  logic [31:0] reg_rdata;
  logic adc_start, adc_sel_temp, adc_valid, fft_start, fft_done;
  logic [13:0] adc_data;
  logic [11:0] win_idx, fft_bin_addr;
  logic signed [15:0] win_coef;
  logic signed [31:0] fft_bin_data;
  vmt_smp_t fft_smp, log_smp;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, rate;
  int sels[3] = '{15, 4, 3};
  always #25 sys_clk = ~sys_clk;
  vmt_core #(.TICK_CYCLES(20)) u_vmt_core (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_connected(link_connected), .adc_start(adc_start),
    .adc_sel_temp(adc_sel_temp), .adc_data(adc_data), .adc_valid(adc_valid),
    .win_idx(win_idx), .win_coef(win_coef), .fft_smp(fft_smp), .fft_start(fft_start),
    .fft_done(fft_done), .fft_bin_addr(fft_bin_addr), .fft_bin_data(fft_bin_data),
    .log_smp(log_smp), .log_commit(), .adv_payload(), .adv_update(), .adv_tx(),
    .threshold_event_flag());
  vmt_far_model u_vmt_far_model (.sys_clk(sys_clk), .rst(rst), .slow(slow),
    .adc_start(adc_start), .adc_sel_temp(adc_sel_temp), .adc_data(adc_data),
    .adc_valid(adc_valid), .win_idx(win_idx), .win_coef(win_coef),
    .fft_start(fft_start), .fft_done(fft_done), .fft_bin_addr(fft_bin_addr),
    .fft_bin_data(fft_bin_data));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so look just past that edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic wait_for(input bit smp, input int lim, output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while ((smp ? log_smp.valid : adc_start) !== 1'b1 && k < lim);
  endtask : wait_for
  task automatic do_reset(input int c);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (c) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic results();
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset(10);
    rd(REG_CTRL, 32'h0);
    rd(REG_INTERVAL, 32'h3C);
    rd(REG_GAIN, 32'h100);
    rd(REG_RMS, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0);
    wr(REG_THR_LEVEL, 32'h1234);
    rd(REG_THR_LEVEL, 32'h1234);
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS, 32'h0);
    wr(REG_FFT_BIN, 32'h5);
    rd(REG_FFT_DATA, 32'h0);
    @(posedge sys_clk);
    link_connected <= 1'b1;
    chk(32'(fft_bin_addr), 32'h5);
    rd(REG_FFT_DATA, 32'hFFFF_0005);
    rd(REG_STATUS, 32'h4);
    // every window code, the last one against a slow converter
    for (int w = 0; w < 4; w++) begin
      do_reset(2);
      slow <= w == 3;
      wr(REG_DC_OFFSET, 32'h100);
      wr(REG_GAIN, 32'h200);
      wr(REG_INTERVAL, 32'h1);
      wr(REG_CTRL, 32'hF1 | 32'(w << 2));
      wait_for(1'b0, 100, n);
      chk(32'(adc_start), 32'h1);
      chk(32'(adc_sel_temp), 32'h0);
      rd(REG_STATUS, 32'h5);
      for (int i = 0; i < 2; i++) begin
        wait_for(1'b1, 400, n);
        chk(32'(log_smp.addr), 32'(i));
        chk(32'(win_idx), 32'(i + 1));
        chk(32'(log_smp.data), 32'h2000 + 32'(i * 32));
        chk(32'(fft_smp.data), (w == 1 || w == 2) ? 32'h1000 + 32'(i * 16)
          : 32'h2000 + 32'(i * 32));
      end
    end
    // live mode pacing across three rates
    for (int j = 0; j < 3; j++) begin
      do_reset(2);
      link_connected <= 1'b0;
      wr(REG_CTRL, 32'(sels[j] * 16 + 2));
      wait_for(1'b0, 60, n);
      chk(32'(adc_start), 32'h0);
      @(posedge sys_clk);
      link_connected <= 1'b1;
      wait_for(1'b0, 10, n);
      chk(32'(adc_start), 32'h1);
      rate = (sels[j] < 4) ? (512 << sels[j]) : 4096 * (sels[j] - 2);
      wait_for(1'b0, 6000, n);
      chk(32'(n), 32'(20000000 / rate));
    end
    results();
  end
endmodule : tb
